// >>> sdd_pkg.sv
// Shared constants and types for the serial daisy-chain converter interface
package sdd_pkg;

   localparam int WORD_W        = 12;
   localparam int FIFO_DEPTH    = 16;
   localparam int CHAIN_DELAY   = 12;

   typedef logic [WORD_W-1:0] sdd_word_t;

   localparam sdd_word_t CLEAR_CODE   = 12'h000;
   localparam sdd_word_t SHIFT_RST    = 12'h000;

   // Bit positions inside the sampled link-pin vector
   localparam int PIN_POS_A     = 0;
   localparam int PIN_POS_B     = 1;
   localparam int PIN_POS_C     = 2;
   localparam int PIN_NEG       = 3;
   localparam int PIN_SERIAL    = 4;
   localparam int PIN_W         = 5;
   localparam logic [PIN_W-1:0] PIN_RST = 5'h08;

   // Bit positions inside the sampled control-pin vector
   localparam int CTL_LOAD_A    = 0;
   localparam int CTL_LOAD_B    = 1;
   localparam int CTL_CLEAR     = 2;
   localparam int CTL_W         = 3;
   localparam logic [CTL_W-1:0] CTL_RST = 3'h7;

endpackage

// >>> sdd_word_if.sv
// Word stream carrier between the load logic and the update FIFO
`timescale 1ns/100ps
`default_nettype none
interface sdd_word_if;
   import sdd_pkg::*;
   logic      push_valid;
   logic      push_ready;
   sdd_word_t push_data;
   logic      pop_valid;
   logic      pop_ready;
   sdd_word_t pop_data;

   modport producer (output push_valid, output push_data, input push_ready,
                     input pop_valid, input pop_data, output pop_ready);
   modport fifo     (input push_valid, input push_data, output push_ready,
                     output pop_valid, output pop_data, input pop_ready);
endinterface
`default_nettype wire

// >>> sdd_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush
`timescale 1ns/100ps
`default_nettype none
module sdd_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
) (
   input  wire logic clk_in,
   input  wire logic srst_in,
   input  wire logic flush_in,
   sdd_word_if.fifo  wif
);
   import sdd_pkg::*;

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wr_ptr_r;
   logic [AW:0]      rd_ptr_r;
   wire  [AW:0]      fill;
   wire              full;
   wire              empty;
   wire              push_fire;
   wire              pop_fire;

   assign fill      = wr_ptr_r - rd_ptr_r;
   assign full      = (fill == DEPTH[AW:0]);
   assign empty     = (fill == '0);
   assign push_fire = wif.push_valid & ~full;
   assign pop_fire  = wif.pop_ready & ~empty;

   assign wif.push_ready = ~full;
   assign wif.pop_valid  = ~empty;
   assign wif.pop_data   = mem_r[rd_ptr_r[AW-1:0]];

   always_ff @(posedge clk_in)
   begin
      if (push_fire)
      begin
         mem_r[wr_ptr_r[AW-1:0]] <= wif.push_data;
      end
   end

   // Flush drops queued words but never a word being read this cycle
   always_ff @(posedge clk_in)
   begin
      if (srst_in || flush_in)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end
      else
      begin
         wr_ptr_r <= wr_ptr_r + (AW+1)'(push_fire);
         rd_ptr_r <= rd_ptr_r + (AW+1)'(pop_fire);
      end
   end

   AST_NO_OVERFILL : assert property (@(posedge clk_in) disable iff (srst_in)
      fill <= DEPTH[AW:0])
      else $error("FIFO fill level above depth");

endmodule
`default_nettype wire

// >>> sdd_dac_interface.sv
// Serial input shifter, daisy-chain output and converter register update
// Behaviour
// - Words enter most significant bit first, one bit per accepted strobe edge.
// - A rising edge on any positive strobe shifts one serial bit in.
// - A falling edge on the inverted strobe shifts one serial bit in.
// - No shifting while a positive strobe is high or inverted strobe low.
// - Chain output repeats the serial input twelve shift edges later.
// - Both load lines low without clear copies the input word across.
// - Either load line high starts no load; words already queued still reach the register.
// - Clear low forces the converter register to zero code.
// - Clear leaves the input shift register untouched.
// - Clear wins over load; register stays zero while clear low.
`timescale 1ns/100ps
`default_nettype none
module sdd_dac_interface (
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   input  wire logic        shift_link_clk_in,
   input  wire logic        shift_strobe_pos_a_in,
   input  wire logic        shift_strobe_pos_b_in,
   input  wire logic        shift_strobe_pos_c_in,
   input  wire logic        shift_strobe_neg_in,
   input  wire logic        serial_in,
   input  wire logic        load_n_first_in,
   input  wire logic        load_n_second_in,
   input  wire logic        clear_n_in,
   input  wire logic        dac_accept_in,
   output logic             serial_chain_out,
   output sdd_pkg::sdd_word_t dac_code_out,
   output logic             load_busy_out
);
   import sdd_pkg::*;

   // Link domain: everything clocked by the controller's shift clock

   logic [1:0]       lrst_sync_r;
   wire              link_rst;
   logic [PIN_W-1:0] pin_meta_r;
   logic [PIN_W-1:0] pin_sync_r;
   logic [PIN_W-1:0] pin_prev_r;
   sdd_word_t        shift_r;
   logic             chain_r;
   sdd_word_t        hold_r;
   logic             req_tgl_r;
   logic             ack_meta_r;
   logic             ack_sync_r;
   // Driven in the system domain, declared here because the link side reads it
   logic             ack_tgl_r;

   wire [PIN_W-1:0]  pin_rise;
   wire [PIN_W-1:0]  pin_fall;
   wire              pos_a_idle;
   wire              pos_b_idle;
   wire              pos_c_idle;
   wire              neg_idle;
   wire              shift_evt;
   wire              send_word;

   assign link_rst   = lrst_sync_r[1];
   assign pin_rise   = pin_sync_r & ~pin_prev_r;
   assign pin_fall   = ~pin_sync_r & pin_prev_r;
   assign pos_a_idle = ~pin_sync_r[PIN_POS_A];
   assign pos_b_idle = ~pin_sync_r[PIN_POS_B];
   assign pos_c_idle = ~pin_sync_r[PIN_POS_C];
   assign neg_idle   = pin_sync_r[PIN_NEG];

   // Each strobe counts only while all the others sit at their enabling level
   assign shift_evt =
      (pin_rise[PIN_POS_A] & pos_b_idle & pos_c_idle & neg_idle) |
      (pin_rise[PIN_POS_B] & pos_a_idle & pos_c_idle & neg_idle) |
      (pin_rise[PIN_POS_C] & pos_a_idle & pos_b_idle & neg_idle) |
      (pin_fall[PIN_NEG] & pos_a_idle & pos_b_idle & pos_c_idle);

   // Offer the latest word only when the previous offer was acknowledged
   assign send_word = (req_tgl_r == ack_sync_r) && (hold_r != shift_r);

   always_ff @(posedge shift_link_clk_in)
   begin
      lrst_sync_r <= {lrst_sync_r[0], srst_in};
   end

   always_ff @(posedge shift_link_clk_in)
   begin
      if (link_rst)
      begin
         pin_meta_r <= PIN_RST;
         pin_sync_r <= PIN_RST;
         pin_prev_r <= PIN_RST;
      end
      else
      begin
         pin_meta_r <= {serial_in, shift_strobe_neg_in, shift_strobe_pos_c_in,
                        shift_strobe_pos_b_in, shift_strobe_pos_a_in};
         pin_sync_r <= pin_meta_r;
         pin_prev_r <= pin_sync_r;
      end
   end

   // Data is taken from the sample before the edge, i.e. on the setup side
   always_ff @(posedge shift_link_clk_in)
   begin
      if (link_rst)
      begin
         shift_r <= SHIFT_RST;
         chain_r <= 1'b0;
      end
      else if (shift_evt)
      begin
         shift_r <= {shift_r[WORD_W-2:0], pin_prev_r[PIN_SERIAL]};
         chain_r <= shift_r[WORD_W-1];
      end
   end

   always_ff @(posedge shift_link_clk_in)
   begin
      if (link_rst)
      begin
         hold_r     <= SHIFT_RST;
         req_tgl_r  <= 1'b0;
         ack_meta_r <= 1'b0;
         ack_sync_r <= 1'b0;
      end
      else
      begin
         ack_meta_r <= ack_tgl_r;
         ack_sync_r <= ack_meta_r;
         if (send_word)
         begin
            hold_r    <= shift_r;
            req_tgl_r <= ~req_tgl_r;
         end
      end
   end

   assign serial_chain_out = chain_r;

   // System domain: word mirror, load and clear handling

   logic             req_meta_r;
   logic             req_sync_r;
   sdd_word_t        mirror_r;
   logic             word_fresh_r;
   logic [CTL_W-1:0] ctl_meta_r;
   logic [CTL_W-1:0] ctl_sync_r;
   logic             load_prev_r;
   logic             pending_r;
   logic             pending_nxt;
   logic             busy_r;
   sdd_word_t        dac_r;
   sdd_word_t        dac_nxt;

   wire              word_take;
   wire              clear_act;
   wire              load_pins_low;
   wire              load_act;
   wire              load_want;
   wire              push_fire;
   wire              pop_fire;

   sdd_word_if wif ();

   sdd_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in   (clk_in),
      .srst_in  (srst_in),
      .flush_in (clear_act),
      .wif      (wif.fifo)
   );

   assign word_take     = (req_sync_r != ack_tgl_r);
   assign clear_act     = ~ctl_sync_r[CTL_CLEAR];
   assign load_pins_low = ~ctl_sync_r[CTL_LOAD_A] & ~ctl_sync_r[CTL_LOAD_B];
   assign load_act      = load_pins_low & ~clear_act;
   // Load is level-true: a new word arriving during a held load goes across
   assign load_want     = load_act & (~load_prev_r | word_fresh_r);
   assign push_fire     = wif.push_valid & wif.push_ready;
   assign pop_fire      = wif.pop_valid & wif.pop_ready;

   assign wif.push_valid = pending_r & ~clear_act;
   assign wif.push_data  = mirror_r;
   assign wif.pop_ready  = dac_accept_in & ~clear_act;

   // A new load request wins over the acceptance of an older one
   assign pending_nxt = ~clear_act & (load_want | (pending_r & ~push_fire));
   assign dac_nxt     = clear_act ? CLEAR_CODE :
                        pop_fire  ? wif.pop_data : dac_r;

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         req_meta_r   <= 1'b0;
         req_sync_r   <= 1'b0;
         ack_tgl_r    <= 1'b0;
         mirror_r     <= SHIFT_RST;
         word_fresh_r <= 1'b0;
      end
      else
      begin
         req_meta_r   <= req_tgl_r;
         req_sync_r   <= req_meta_r;
         word_fresh_r <= word_take;
         if (word_take)
         begin
            mirror_r  <= hold_r;
            ack_tgl_r <= req_sync_r;
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         ctl_meta_r <= CTL_RST;
         ctl_sync_r <= CTL_RST;
      end
      else
      begin
         ctl_meta_r <= {clear_n_in, load_n_second_in, load_n_first_in};
         ctl_sync_r <= ctl_meta_r;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         load_prev_r <= 1'b0;
         pending_r   <= 1'b0;
         busy_r      <= 1'b0;
         dac_r       <= CLEAR_CODE;
      end
      else
      begin
         load_prev_r <= load_act;
         pending_r   <= pending_nxt;
         busy_r      <= pending_nxt;
         dac_r       <= dac_nxt;
      end
   end

   assign dac_code_out  = dac_r;
   assign load_busy_out = busy_r;

   // Checks, link domain

   sequence s_shift_edge;
      shift_evt;
   endsequence

   sequence s_neg_edge_alone;
      pin_fall[PIN_NEG] && pos_a_idle && pos_b_idle && pos_c_idle;
   endsequence

   property p_msb_first;
      @(posedge shift_link_clk_in) disable iff (link_rst)
      s_shift_edge |=> (shift_r[0] == $past(pin_prev_r[PIN_SERIAL]))
                       && (shift_r[WORD_W-1:1] == $past(shift_r[WORD_W-2:0]));
   endproperty

   AST_MSB_FIRST : assert property (p_msb_first)
      else $error("Serial bit not shifted in at the low end");

   AST_POS_EDGE_SHIFT : assert property (@(posedge shift_link_clk_in)
      disable iff (link_rst)
      (pin_rise[PIN_POS_B] && pos_a_idle && pos_c_idle && neg_idle)
      |=> shift_r[WORD_W-1:1] == $past(shift_r[WORD_W-2:0]))
      else $error("Rising strobe edge did not shift");

   AST_NEG_EDGE_SHIFT : assert property (@(posedge shift_link_clk_in)
      disable iff (link_rst)
      s_neg_edge_alone |=> shift_r[0] == $past(pin_prev_r[PIN_SERIAL]))
      else $error("Falling inverted strobe edge did not shift");

   AST_INHIBIT : assert property (@(posedge shift_link_clk_in)
      disable iff (link_rst)
      (pin_sync_r[PIN_POS_A] || !pin_sync_r[PIN_NEG]) && pin_prev_r[PIN_POS_A]
      == pin_sync_r[PIN_POS_A] && pin_prev_r[PIN_NEG] == pin_sync_r[PIN_NEG]
      |=> $stable(shift_r))
      else $error("Shift while a strobe held its inhibit level");

   AST_CHAIN_DELAY : assert property (@(posedge shift_link_clk_in)
      disable iff (link_rst)
      s_shift_edge |=> serial_chain_out == $past(shift_r[WORD_W-1]))
      else $error("Chain output is not the bit leaving the register");

   // Checks, system domain

   sequence s_load_start;
      $rose(load_act) && !pending_r;
   endsequence

   sequence s_queued;
      pending_r ##[1:40] !pending_r;
   endsequence

   AST_LOAD_QUEUES : assert property (@(posedge clk_in) disable iff (srst_in)
      s_load_start |=> pending_r && load_busy_out)
      else $error("Load request not registered");

   AST_LOAD_TAKES : assert property (@(posedge clk_in) disable iff (srst_in)
      pop_fire && !clear_act |=> dac_code_out == $past(wif.pop_data))
      else $error("Converter register missed a queued word");

   AST_HOLD : assert property (@(posedge clk_in) disable iff (srst_in)
      !clear_act && !pop_fire |=> $stable(dac_code_out))
      else $error("Converter register moved without load or clear");

   AST_CLEAR_ZERO : assert property (@(posedge clk_in) disable iff (srst_in)
      clear_act |=> dac_code_out == CLEAR_CODE && !pending_r)
      else $error("Clear did not zero the converter register");

   AST_CLEAR_KEEPS_WORD : assert property (@(posedge clk_in) disable iff (srst_in)
      clear_act && !word_take |=> $stable(mirror_r))
      else $error("Clear disturbed the input word");

   AST_CLEAR_PRIORITY : assert property (@(posedge clk_in) disable iff (srst_in)
      clear_act && load_pins_low [*2] |=> dac_code_out == CLEAR_CODE)
      else $error("Load overrode clear");

   AST_QUEUE_DRAINS : assert property (@(posedge clk_in) disable iff (srst_in)
      s_load_start ##1 wif.push_ready [*2] |-> !pending_r || clear_act)
      else $error("Queued load never entered the FIFO");

endmodule
`default_nettype wire

// >>> sdd_ctl_model.sv
// Controller model driving the strobe, serial, load and clear pins
`timescale 1ns/100ps
`default_nettype none
module sdd_ctl_model
   import sdd_pkg::*;
(
   input  wire logic       lclk_in,
   input  wire logic       clk_in,
   input  wire logic       chain_in,
   output logic [3:0]      strobe_out,
   output logic            serial_out,
   output logic [1:0]      load_n_out,
   output logic            clear_n_out,
   output sdd_word_t       caught_out
);
   initial
   begin
      strobe_out  = 4'h8;
      serial_out  = 1'b0;
      load_n_out  = 2'h3;
      clear_n_out = 1'b1;
      caught_out  = SHIFT_RST;
   end

   // Timing is slow on purpose: every strobe and serial pin passes a 2FF on the link clock
   task automatic shift_word(input sdd_word_t w, input int sel, input bit inhibit);
      logic [3:0] act;
      act = 4'h8 ^ (4'h1 << sel);
      for (int i = WORD_W - 1; i >= 0; i--)
      begin
         @(posedge lclk_in);
         serial_out <= w[i];
         repeat (2) @(posedge lclk_in);
         strobe_out <= act;
         repeat (2) @(posedge lclk_in);
         if (inhibit)
         begin
            strobe_out <= act ^ ((sel == 0) ? 4'h2 : 4'h1);
            repeat (3) @(posedge lclk_in);
            strobe_out <= act;
            repeat (3) @(posedge lclk_in);
         end
         strobe_out <= 4'h8;
         repeat (5) @(posedge lclk_in);
         caught_out <= {caught_out[WORD_W-2:0], chain_in};
      end
      @(posedge lclk_in);
      serial_out <= ~w[0];
      // Word must cross to the core clock before any load
      repeat (4) @(posedge lclk_in);
   endtask

   task automatic pulse_load(input logic [1:0] ld);
      @(posedge clk_in);
      load_n_out <= ld;
      repeat (5) @(posedge clk_in);
      load_n_out <= 2'h3;
      repeat (5) @(posedge clk_in);
   endtask

   task automatic set_clear(input logic v);
      @(posedge clk_in);
      clear_n_out <= v;
      repeat (6) @(posedge clk_in);
   endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the serial daisy-chain converter interface
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import sdd_pkg::*;
   logic       clk_in     = 1'b0;
   logic       lclk       = 1'b0;
   logic       srst_in    = 1'b1;
   logic       dac_accept = 1'b1;
   logic [3:0] strobe;
   logic       serial;
   logic       clear_n;
   logic       chain;
   logic       busy;
   logic [1:0] load_n;
   logic       strobe_a;
   logic       strobe_b;
   logic       strobe_c;
   logic       strobe_neg;
   logic       load_first_n;
   logic       load_second_n;
   sdd_word_t  caught;
   sdd_word_t  dac_code;
   int         err_total       = 0;
   int         samples_checked = 0;
   int         cyc             = 0;
   sdd_word_t  words [4] = '{12'hA5C, 12'h3E1, 12'h801, 12'h7FE};

   assign strobe_a      = strobe[PIN_POS_A];
   assign strobe_b      = strobe[PIN_POS_B];
   assign strobe_c      = strobe[PIN_POS_C];
   assign strobe_neg    = strobe[PIN_NEG];
   assign load_first_n  = load_n[0];
   assign load_second_n = load_n[1];

   sdd_dac_interface u_sdd_dac_interface (
      .clk_in                (clk_in),
      .srst_in               (srst_in),
      .shift_link_clk_in     (lclk),
      .shift_strobe_pos_a_in (strobe_a),
      .shift_strobe_pos_b_in (strobe_b),
      .shift_strobe_pos_c_in (strobe_c),
      .shift_strobe_neg_in   (strobe_neg),
      .serial_in             (serial),
      .load_n_first_in       (load_first_n),
      .load_n_second_in      (load_second_n),
      .clear_n_in            (clear_n),
      .dac_accept_in         (dac_accept),
      .serial_chain_out      (chain),
      .dac_code_out          (dac_code),
      .load_busy_out         (busy)
   );

   sdd_ctl_model u_sdd_ctl_model (
      .lclk_in     (lclk),
      .clk_in      (clk_in),
      .chain_in    (chain),
      .strobe_out  (strobe),
      .serial_out  (serial),
      .load_n_out  (load_n),
      .clear_n_out (clear_n),
      .caught_out  (caught)
   );

   always #5 clk_in = ~clk_in;

   initial
   begin
      #7;
      forever #24 lclk = ~lclk;
   end

   task automatic check(input sdd_word_t seen, input sdd_word_t exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 12000)
      begin
         err_total++;
         complete_run();
      end
   end

   task automatic t_strobes();
      sdd_word_t prev;
      prev = SHIFT_RST;
      for (int s = 0; s < 4; s++)
      begin
         u_sdd_ctl_model.shift_word(words[s], s, 1'b0);
         check(caught, prev, "chain out");
         u_sdd_ctl_model.pulse_load(2'h0);
         check(dac_code, words[s], "strobe word");
         prev = words[s];
      end
      $display("strobe test done");
   endtask

   task automatic t_inhibit();
      u_sdd_ctl_model.shift_word(12'h5A3, 0, 1'b1);
      check(caught, 12'h7FE, "chain with inhibit");
      u_sdd_ctl_model.shift_word(12'hC3C, 3, 1'b1);
      check(caught, 12'h5A3, "chain with neg inhibit");
      u_sdd_ctl_model.pulse_load(2'h0);
      check(dac_code, 12'hC3C, "inhibited word");
      $display("inhibit test done");
   endtask

   task automatic t_hold();
      u_sdd_ctl_model.shift_word(12'h2B7, 2, 1'b0);
      check(dac_code, 12'hC3C, "converter during shift");
      u_sdd_ctl_model.pulse_load(2'h1);
      u_sdd_ctl_model.pulse_load(2'h2);
      check(dac_code, 12'hC3C, "single load line");
      $display("hold test done");
   endtask

   task automatic t_clear();
      u_sdd_ctl_model.set_clear(1'b0);
      check(dac_code, CLEAR_CODE, "cleared");
      u_sdd_ctl_model.pulse_load(2'h0);
      check(dac_code, CLEAR_CODE, "load under clear");
      u_sdd_ctl_model.set_clear(1'b1);
      check(dac_code, CLEAR_CODE, "after clear release");
      u_sdd_ctl_model.pulse_load(2'h0);
      check(dac_code, 12'h2B7, "word kept through clear");
      $display("clear test done");
   endtask

   task automatic t_fifo();
      @(posedge clk_in);
      dac_accept <= 1'b0;
      u_sdd_ctl_model.shift_word(12'h6D9, 1, 1'b0);
      repeat (16) u_sdd_ctl_model.pulse_load(2'h0);
      check(sdd_word_t'(busy), 12'h000, "busy with 16 queued");
      check(dac_code, 12'h2B7, "stalled converter");
      u_sdd_ctl_model.pulse_load(2'h0);
      check(sdd_word_t'(busy), 12'h001, "busy when full");
      @(posedge clk_in);
      dac_accept <= 1'b1;
      repeat (60) @(posedge clk_in);
      check(sdd_word_t'(busy), 12'h000, "drained");
      check(dac_code, 12'h6D9, "drained word");
      $display("fifo test done");
   endtask

   initial
   begin
      // Longer than 5 cycles so the link side also sees reset
      repeat (16) @(posedge clk_in);
      srst_in <= 1'b0;
      repeat (20) @(posedge clk_in);
      t_strobes();
      t_inhibit();
      t_hold();
      t_clear();
      t_fifo();
      complete_run();
   end
endmodule
`default_nettype wire
